/* sp_ctrl.sv */
// Overview of operation
// - Mode 1 multiprocessor needs stop one, address match.
// - Modes 2/3 multiprocessor needs ninth one, match.
// - Reception runs only while receive enable set.
// - Mode 0 receives one byte per enable rise.
// - Ninth transmitted bit sent in modes 2, 3.
// - Ninth received bit or mode 1 stop loaded.
// - Transmit done set after last frame bit.
// - Enabled done flags raise interrupt; software clears.
// - Receive done set after last sampled bit.
// - Mode bits pick frame of 8/10/11/11.
// - Mode 0 divides clock by 12 or 4.
// - Modes 1, 3 divide overflows by 32/16.
// - Multiprocessor bit or double baud picks faster.
// - Mode 1 frame: start, 8 data LSB first, stop.
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "sp_consts.svh"
module sp_ctrl
  import sp_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        timer1_ovf,
  input  wire logic        rxd_in,
  output var  logic        rxd_out,
  output var  logic        rxd_oe,
  output var  logic        txd_out,
  output var  logic        irq
);
  sp_ctrl_t     ctrl_reg;
  sp_flags_t    flags;
  sp_flags_t    ien_reg;
  sp_mode_t     mode;
  sp_tx_state_t tx_state_reg;
  sp_rx_state_t rx_state_reg;
  logic         double_baud_reg;
  logic [7:0]   given_addr_reg;
  logic [7:0]   rx_buf_reg;
  logic         rx_ninth_bit_reg;
  logic [10:0]  tx_sr_reg;
  logic [3:0]   tx_cnt_reg;
  logic [8:0]   rx_sr_reg;
  logic [3:0]   rx_cnt_reg;
  logic         rxd_prev_reg;
  logic         ren_prev_reg;
  logic         acc;
  logic         wr;
  logic         mapped;
  logic [31:0]  rdata;
  logic         mpe;
  logic         m0;
  logic [6:0]   div;
  logic         src_en;
  logic [3:0]   tx_bits;
  logic         tx_start;
  logic         tx_mid;
  logic         tx_bit;
  logic         tx_set;
  logic         rx_go;
  logic         rx_mid;
  logic         rx_bit;
  logic         rx_last;
  logic [8:0]   rx_word;
  logic         match;
  logic         rx_accept;
  logic         rx_set;
  logic         int_pending;

  // ============================================================
  // APB slave with one wait state.
  assign acc = psel && penable;
  assign wr  = acc && pready && pwrite;

  always_comb begin
    mapped = 1'b1;
    rdata  = '0;
    case (paddr)
      `SP_OFF_CTRL: rdata = {24'h000000, ctrl_reg, rx_ninth_bit_reg, flags};
      `SP_OFF_DATA: rdata = {24'h000000, rx_buf_reg};
      `SP_OFF_AUX:  rdata = {31'h0, double_baud_reg};
      `SP_OFF_STAT: rdata = {30'h0, flags};
      `SP_OFF_CLR:  rdata = '0;
      `SP_OFF_IEN:  rdata = {30'h0, ien_reg};
      `SP_OFF_ADDR: rdata = {24'h000000, given_addr_reg};
      default:      mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= acc && !pready;
      pslverr <= acc && !pready && !mapped;
      prdata  <= (acc && !pready && !pwrite) ? rdata : '0;
    end
  end

  // ============================================================
  // Software registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg        <= `SP_CTRL_RST;
      double_baud_reg <= 1'b0;
      ien_reg         <= '0;
      given_addr_reg  <= `SP_ADDR_RST;
    end else if (wr) begin
      case (paddr)
        `SP_OFF_CTRL: ctrl_reg        <= pwdata[`SP_B_MSH:`SP_B_TB8];
        `SP_OFF_AUX:  double_baud_reg <= pwdata[`SP_B_DB];
        `SP_OFF_IEN:  ien_reg         <= pwdata[1:0];
        `SP_OFF_ADDR: given_addr_reg  <= pwdata[7:0];
        default:      ;
      endcase
    end
  end

  // ============================================================
  // Mode decode and bit rate.
  assign mode   = sp_mode_t'({ctrl_reg.mode_select_high, ctrl_reg.mode_select_low});
  assign mpe    = ctrl_reg.multiprocessor_enable;
  assign m0     = (mode == SP_MODE0);
  assign src_en = (mode == SP_MODE1) || (mode == SP_MODE3) ? timer1_ovf : 1'b1;

  always_comb begin
    case (mode)
      SP_MODE0: div = mpe ? `SP_DIV_M0F : `SP_DIV_M0;
      SP_MODE2: div = double_baud_reg ? `SP_DIV_M2F : `SP_DIV_M2;
      default:  div = double_baud_reg ? `SP_DIV_T1F : `SP_DIV_T1;
    endcase
    case (mode)
      SP_MODE0: tx_bits = `SP_BITS_M0;
      SP_MODE1: tx_bits = `SP_BITS_M1;
      default:  tx_bits = `SP_BITS_M23;
    endcase
  end

  // ============================================================
  // Transmitter.
  assign tx_start = wr && (paddr == `SP_OFF_DATA) && (tx_state_reg == TX_IDLE);
  assign tx_set   = (tx_state_reg == TX_SHIFT) && tx_bit && (tx_cnt_reg == 4'h1);

  sp_baud #(.W(7)) u_tx_baud (
    .pclk     (pclk),
    .presetn  (presetn),
    .restart  (tx_start),
    .src_en   (src_en),
    .div      (div),
    .mid_tick (tx_mid),
    .bit_tick (tx_bit)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_reg <= TX_IDLE;
      tx_sr_reg    <= '1;
      tx_cnt_reg   <= '0;
    end else begin
      case (tx_state_reg)
        TX_IDLE: begin
          if (tx_start) begin
            tx_state_reg <= TX_SHIFT;
            tx_cnt_reg   <= tx_bits;
            case (mode)
              SP_MODE0: tx_sr_reg <= {3'h7, pwdata[7:0]};
              SP_MODE1: tx_sr_reg <= {2'h3, pwdata[7:0], 1'b0};
              default:  tx_sr_reg <= {1'b1, ctrl_reg.tx_ninth_bit, pwdata[7:0], 1'b0};
            endcase
          end
        end
        TX_SHIFT: begin
          if (tx_bit) begin
            tx_sr_reg  <= {1'b1, tx_sr_reg[10:1]};
            tx_cnt_reg <= tx_cnt_reg - 1'b1;
            if (tx_cnt_reg == 4'h1) begin
              tx_state_reg <= TX_IDLE;
            end
          end
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  // ============================================================
  // Line outputs; mode 0 drives the shift clock on the transmit pin.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd_out <= 1'b1;
      rxd_out <= 1'b1;
      rxd_oe  <= 1'b0;
    end else begin
      rxd_oe  <= m0 && (tx_state_reg == TX_SHIFT);
      rxd_out <= tx_sr_reg[0];
      if (m0 && tx_state_reg == TX_SHIFT) begin
        txd_out <= tx_mid ? 1'b1 : ((tx_bit && tx_cnt_reg != 4'h1) ? 1'b0 : txd_out);
      end else if (m0 && rx_state_reg == RX_DATA) begin
        txd_out <= rx_mid ? 1'b1 : (rx_bit ? 1'b0 : txd_out);
      end else if (m0) begin
        txd_out <= !(tx_start || rx_go);
      end else begin
        txd_out <= (tx_state_reg == TX_SHIFT) ? tx_sr_reg[0] : 1'b1;
      end
    end
  end

  // ============================================================
  // Receiver.
  assign rx_go = (rx_state_reg == RX_IDLE) && ctrl_reg.receive_enable &&
                 (m0 ? (!ren_prev_reg && !flags.rx_done_flag && tx_state_reg == TX_IDLE)
                     : (rxd_prev_reg && !rxd_in));
  assign rx_last   = (rx_state_reg == RX_DATA) && rx_mid && (rx_cnt_reg == 4'h1);
  assign rx_word   = {rxd_in, rx_sr_reg[8:1]};
  assign match     = (rx_word[7:0] == given_addr_reg) || (rx_word[7:0] == `SP_BCAST);
  assign rx_accept = !flags.rx_done_flag && (m0 || !mpe || (rx_word[8] && match));
  assign rx_set    = rx_last && rx_accept;

  sp_baud #(.W(7)) u_rx_baud (
    .pclk     (pclk),
    .presetn  (presetn),
    .restart  (rx_go),
    .src_en   (src_en),
    .div      (div),
    .mid_tick (rx_mid),
    .bit_tick (rx_bit)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_prev_reg <= 1'b1;
      ren_prev_reg <= 1'b0;
    end else begin
      rxd_prev_reg <= rxd_in;
      ren_prev_reg <= ctrl_reg.receive_enable;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_reg <= RX_IDLE;
      rx_sr_reg    <= '0;
      rx_cnt_reg   <= '0;
    end else if (!ctrl_reg.receive_enable) begin
      rx_state_reg <= RX_IDLE;
    end else begin
      case (rx_state_reg)
        RX_IDLE: begin
          if (rx_go) begin
            rx_state_reg <= m0 ? RX_DATA : RX_START;
            rx_cnt_reg   <= m0 ? `SP_BITS_M0 : `SP_BITS_RXA;
          end
        end
        RX_START: begin
          if (rx_mid) begin
            rx_state_reg <= rxd_in ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_mid) begin
            rx_sr_reg  <= rx_word;
            rx_cnt_reg <= rx_cnt_reg - 1'b1;
            if (rx_cnt_reg == 4'h1) begin
              rx_state_reg <= RX_IDLE;
            end
          end
        end
        default: rx_state_reg <= RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_buf_reg       <= '0;
      rx_ninth_bit_reg <= 1'b0;
    end else if (rx_set) begin
      rx_buf_reg <= m0 ? rx_word[8:1] : rx_word[7:0];
      if (!m0) begin
        rx_ninth_bit_reg <= rx_word[8];
      end
    end
  end

  // ============================================================
  // Done flags and interrupt.
  sp_flag u_tx_flag (
    .pclk    (pclk),
    .presetn (presetn),
    .set     (tx_set),
    .clr     (wr && paddr == `SP_OFF_CLR && pwdata[`SP_B_TXF]),
    .q       (flags.tx_done_flag)
  );

  sp_flag u_rx_flag (
    .pclk    (pclk),
    .presetn (presetn),
    .set     (rx_set),
    .clr     (wr && paddr == `SP_OFF_CLR && pwdata[`SP_B_RXF]),
    .q       (flags.rx_done_flag)
  );

  assign int_pending = |(flags & ien_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= int_pending;
    end
  end

  // ============================================================
  // Assertions.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_TX_DONE_SET: assert property (tx_set |=> flags.tx_done_flag)
    else $error("Transmit done not set.");
  AST_FLAG_HOLD: assert property (flags.rx_done_flag &&
    !(wr && paddr == `SP_OFF_CLR && pwdata[`SP_B_RXF]) |=> flags.rx_done_flag)
    else $error("Receive done cleared by hardware.");
  AST_IRQ: assert property (##1 (irq == $past(int_pending)))
    else $error("Interrupt does not follow enabled flags.");
  AST_REN_OFF: assert property (!ctrl_reg.receive_enable |=> rx_state_reg == RX_IDLE)
    else $error("Reception active while disabled.");
  AST_M1_QUAL: assert property (rx_set && mode == SP_MODE1 && mpe |-> rx_word[8] && match)
    else $error("Mode 1 frame accepted without valid stop.");
  AST_M23_QUAL: assert property (rx_set && mode[1] && mpe |-> rx_word[8] && match)
    else $error("Frame accepted without ninth bit.");
  AST_TB8_SENT: assert property (tx_start && mode[1] |=> tx_sr_reg[9] == $past(ctrl_reg.tx_ninth_bit))
    else $error("Ninth transmit bit wrong.");
  AST_FRAME_LEN: assert property (tx_start |=> tx_cnt_reg == $past(tx_bits))
    else $error("Frame length wrong.");
  AST_RB8_LOAD: assert property (rx_set && !m0 |=> rx_ninth_bit_reg == $past(rxd_in))
    else $error("Ninth receive bit not loaded.");
  AST_M0_ONCE: assert property (rx_state_reg == RX_IDLE && m0 && ren_prev_reg
    |=> rx_state_reg == RX_IDLE)
    else $error("Mode 0 reception without enable rise.");

  COV_TX_DONE: cover property (tx_set);
  COV_RX_DONE: cover property (rx_set && !m0);
  COV_M0_RX: cover property (rx_set && m0);
  COV_IRQ: cover property (irq);
endmodule : sp_ctrl
`default_nettype wire

/* sp_consts.svh */
`ifndef SP_CONSTS_SVH
`define SP_CONSTS_SVH
// ============================================================
// Register offsets.
`define SP_OFF_CTRL  8'h00
`define SP_OFF_DATA  8'h04
`define SP_OFF_AUX   8'h08
`define SP_OFF_STAT  8'h0C
`define SP_OFF_CLR   8'h10
`define SP_OFF_IEN   8'h14
`define SP_OFF_ADDR  8'h18
// ============================================================
// Field positions.
`define SP_B_MSH     7
`define SP_B_MSL     6
`define SP_B_MPE     5
`define SP_B_REN     4
`define SP_B_TB8     3
`define SP_B_RB8     2
`define SP_B_TXF     1
`define SP_B_RXF     0
`define SP_B_DB      0
// ============================================================
// Reset values and broadcast address.
`define SP_CTRL_RST  5'h00
`define SP_ADDR_RST  8'h00
`define SP_BCAST     8'hFF
// ============================================================
// Bit rate divisors.
`define SP_DIV_M0    7'h0C
`define SP_DIV_M0F   7'h04
`define SP_DIV_M2    7'h40
`define SP_DIV_M2F   7'h20
`define SP_DIV_T1    7'h20
`define SP_DIV_T1F   7'h10
// ============================================================
// Frame lengths.
`define SP_BITS_M0   4'h8
`define SP_BITS_M1   4'hA
`define SP_BITS_M23  4'hB
`define SP_BITS_RXA  4'h9
`endif

/* sp_pkg.sv */
`default_nettype none
package sp_pkg;
  // ============================================================
  // Types shared by the port logic.
  typedef enum logic [1:0] {SP_MODE0, SP_MODE1, SP_MODE2, SP_MODE3} sp_mode_t;
  typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} sp_tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} sp_rx_state_t;
  typedef struct packed {
    logic mode_select_high;
    logic mode_select_low;
    logic multiprocessor_enable;
    logic receive_enable;
    logic tx_ninth_bit;
  } sp_ctrl_t;
  typedef struct packed {
    logic tx_done_flag;
    logic rx_done_flag;
  } sp_flags_t;
endpackage : sp_pkg
`default_nettype wire

/* sp_baud.sv */
`timescale 1ns/1ns
`default_nettype none
module sp_baud #(
  parameter int W = 7
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         restart,
  input  wire logic         src_en,
  input  wire logic [W-1:0] div,
  output var  logic         mid_tick,
  output var  logic         bit_tick
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] half;

  // ============================================================
  // Counts source events and marks the middle and end of each bit.
  assign half     = div >> 1;
  assign mid_tick = src_en && !restart && (cnt_reg == half - 1'b1);
  assign bit_tick = src_en && !restart && (cnt_reg == div - 1'b1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
    end else if (restart || bit_tick) begin
      cnt_reg <= '0;
    end else if (src_en) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end
endmodule : sp_baud
`default_nettype wire

/* sp_flag.sv */
`timescale 1ns/1ns
`default_nettype none
module sp_flag (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic set,
  input  wire logic clr,
  output var  logic q
);
  // ============================================================
  // Sticky flag; a set in the clearing cycle wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= 1'b0;
    end else if (set) begin
      q <= 1'b1;
    end else if (clr) begin
      q <= 1'b0;
    end
  end
endmodule : sp_flag
`default_nettype wire

/* sp_remote.sv */
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// Remote serial device on the line side.
module sp_remote #(
  parameter int PERIOD_NS = 10
) (
  input  wire logic pclk,
  input  wire logic line_in,
  input  wire logic data_in,
  input  wire logic data_oe,
  output var  logic line_out
);
  initial line_out = 1'h1;

  // Sends start, data LSB first, then ninth bit and stop, or b9 as the stop.
  task automatic send(input int cyc, input logic [7:0] d, input logic b9, input logic has9);
    logic [10:0] fr;
    int          n;
    fr = {1'h1, b9, d, 1'h0};
    n = has9 ? 11 : 10;
    for (int i = 0; i < n; i++) begin
      line_out <= fr[i];
      repeat (cyc) @(posedge pclk);
    end
    line_out <= 1'h1;
  endtask : send

  // Samples n bits at mid-bit after a falling edge on the line.
  task automatic recv(input int cyc, input int n, output logic [10:0] fr);
    fr = 11'h7FF;
    @(posedge pclk iff line_in === 1'h0);
    repeat (cyc / 2) @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      fr[i] = line_in;
      repeat (cyc) @(posedge pclk);
    end
  endtask : recv

  // Mode 0: takes a bit at each rising shift clock, times the seven periods from first to eighth, waits for release.
  task automatic shift_in(output logic [7:0] d, output logic oe, output int cyc);
    time t0;
    d  = 8'h00;
    oe = 1'h1;
    t0 = 0;
    for (int i = 0; i < 8; i++) begin
      @(posedge line_in);
      if (i == 0) t0 = $time;
      d[i] = data_in;
      oe   = oe & data_oe;
    end
    cyc = int'(($time - t0) / PERIOD_NS);
    @(posedge pclk iff data_oe === 1'h0);
  endtask : shift_in

  // Mode 0: presents a bit after each falling shift clock, LSB first.
  task automatic shift_out(input logic [7:0] d, output int cyc);
    time t0;
    t0 = 0;
    for (int i = 0; i < 8; i++) begin
      @(negedge line_in);
      if (i == 0) t0 = $time;
      line_out <= d[i];
    end
    cyc = int'(($time - t0) / PERIOD_NS);
    @(posedge line_in);
    line_out <= 1'h1;
  endtask : shift_out
endmodule : sp_remote
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "sp_consts.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s exp %0h got %0h", nm, e, g); end end
// ============================================================
// Self-checking bench for the serial port control.
module tb;
  typedef struct packed {
    logic [1:0] md;
    logic       mp;
    logic       en;
    logic [7:0] d;
    logic       b9;
    logic       ok;
  } sp_row_t;
  typedef struct packed {
    logic [1:0] md;
    logic       tb;
    logic [7:0] d;
    logic       db;
  } sp_txrow_t;
  logic        pclk, presetn, psel, penable, pwrite, rxd_in;
  logic        timer1_ovf = 1'h0;
  logic [7:0]  m0d;
  logic        m0oe;
  int          m0cyc;
  logic        pready, pslverr, rxd_out, rxd_oe, txd_out, irq, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [10:0] fr, ex;
  int          n_fail, n_tests;
  int          cyc_cnt = 0;
  sp_row_t     rows [10] = '{
    '{2'h2, 1'h0, 1'h1, 8'hA5, 1'h0, 1'h1}, '{2'h3, 1'h0, 1'h1, 8'h3C, 1'h1, 1'h1},
    '{2'h2, 1'h1, 1'h1, 8'h5A, 1'h1, 1'h1}, '{2'h2, 1'h1, 1'h1, 8'h5A, 1'h0, 1'h0},
    '{2'h3, 1'h1, 1'h1, 8'h33, 1'h1, 1'h0}, '{2'h3, 1'h1, 1'h1, 8'hFF, 1'h1, 1'h1},
    '{2'h1, 1'h0, 1'h1, 8'hC3, 1'h0, 1'h1}, '{2'h1, 1'h1, 1'h1, 8'h5A, 1'h0, 1'h0},
    '{2'h1, 1'h1, 1'h1, 8'h5A, 1'h1, 1'h1}, '{2'h2, 1'h0, 1'h0, 8'h77, 1'h1, 1'h0}};
  sp_txrow_t   txr [4] = '{'{2'h2, 1'h1, 8'h96, 1'h0}, '{2'h3, 1'h0, 8'h4E, 1'h1},
    '{2'h1, 1'h1, 8'hB1, 1'h0}, '{2'h2, 1'h1, 8'h0F, 1'h1}};

  sp_ctrl sp_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer1_ovf(timer1_ovf), .rxd_in(rxd_in), .rxd_out(rxd_out),
    .rxd_oe(rxd_oe), .txd_out(txd_out), .irq(irq));
  sp_remote sp_remote_inst (.pclk(pclk), .line_in(txd_out), .data_in(rxd_out),
    .data_oe(rxd_oe), .line_out(rxd_in));

  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end

  // Timer overflow every second cycle gives 64 clocks per bit at divide by 32.
  always @(posedge pclk) timer1_ovf <= ~timer1_ovf;

  always @(posedge pclk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 40000) begin
      n_fail++;
      wrap_up();
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  initial begin
    presetn = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0;
    paddr = 8'h00; pwdata = 32'h0; n_fail = 0; n_tests = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    for (int a = 0; a < 28; a += 4) begin
      apb(1'h0, a[7:0], 32'h0);
      `CHK("reset value", 32'h0, rd)
    end
    apb(1'h0, 8'h1C, 32'h0);
    `CHK("unmapped error", 1'h1, er)
    apb(1'h1, `SP_OFF_CTRL, 32'hFF);
    apb(1'h0, `SP_OFF_CTRL, 32'h0);
    `CHK("ctrl readback", 32'hF8, rd)
    $display("test registers done");
    apb(1'h1, `SP_OFF_ADDR, 32'h5A);
    apb(1'h1, `SP_OFF_IEN, 32'h3);
    foreach (rows[i]) begin
      apb(1'h1, `SP_OFF_CTRL, {24'h0, rows[i].md, rows[i].mp, rows[i].en, 4'h0});
      sp_remote_inst.send(64, rows[i].d, rows[i].b9, rows[i].md != 2'h1);
      apb(1'h0, `SP_OFF_STAT, 32'h0);
      `CHK("rx_done", {31'h0, rows[i].ok}, rd)
      `CHK("irq", rows[i].ok, irq)
      if (rows[i].ok) begin
        apb(1'h0, `SP_OFF_DATA, 32'h0);
        `CHK("rx data", {24'h0, rows[i].d}, rd)
        apb(1'h0, `SP_OFF_CTRL, 32'h0);
        `CHK("rx_ninth_bit", rows[i].b9, rd[`SP_B_RB8])
      end
      apb(1'h1, `SP_OFF_CLR, 32'h3);
      $display("test rx row %0d done", i);
    end
    foreach (txr[i]) begin
      apb(1'h1, `SP_OFF_AUX, {31'h0, txr[i].db});
      apb(1'h1, `SP_OFF_CTRL, {24'h0, txr[i].md, 2'h0, txr[i].tb, 3'h0});
      fork
        apb(1'h1, `SP_OFF_DATA, {24'h0, txr[i].d});
        sp_remote_inst.recv(txr[i].db ? 32 : 64, 11, fr);
      join
      ex = (txr[i].md == 2'h1) ? {2'h3, txr[i].d, 1'h0} : {1'h1, txr[i].tb, txr[i].d, 1'h0};
      `CHK("tx frame", ex, fr)
      apb(1'h0, `SP_OFF_STAT, 32'h0);
      `CHK("tx_done", 32'h2, rd)
      `CHK("irq", 1'h1, irq)
      if (i < 3) apb(1'h1, `SP_OFF_CLR, 32'h2);
      $display("test tx row %0d done", i);
    end
    apb(1'h1, `SP_OFF_IEN, 32'h0);
    apb(1'h0, `SP_OFF_STAT, 32'h0);
    `CHK("masked status", 32'h2, rd)
    `CHK("masked irq", 1'h0, irq)
    apb(1'h1, `SP_OFF_CLR, 32'h2);
    apb(1'h1, `SP_OFF_IEN, 32'h3);
    apb(1'h0, `SP_OFF_STAT, 32'h0);
    `CHK("cleared status", 32'h0, rd)
    `CHK("cleared irq", 1'h0, irq)
    $display("test interrupt done");
    apb(1'h1, `SP_OFF_CTRL, 32'h0);
    fork
      apb(1'h1, `SP_OFF_DATA, 32'hC5);
      sp_remote_inst.shift_in(m0d, m0oe, m0cyc);
    join
    `CHK("mode 0 tx data", 8'hC5, m0d)
    `CHK("mode 0 data enable", 1'h1, m0oe)
    `CHK("mode 0 tx period", 84, m0cyc)
    apb(1'h0, `SP_OFF_STAT, 32'h0);
    `CHK("mode 0 tx_done", 32'h2, rd)
    `CHK("mode 0 release", 1'h0, rxd_oe)
    apb(1'h1, `SP_OFF_CLR, 32'h3);
    fork
      apb(1'h1, `SP_OFF_CTRL, 32'h30);
      sp_remote_inst.shift_out(8'h6B, m0cyc);
    join
    `CHK("mode 0 rx period", 28, m0cyc)
    apb(1'h0, `SP_OFF_STAT, 32'h0);
    `CHK("mode 0 rx_done", 32'h1, rd)
    apb(1'h0, `SP_OFF_DATA, 32'h0);
    `CHK("mode 0 rx data", 32'h6B, rd)
    apb(1'h1, `SP_OFF_CLR, 32'h3);
    repeat (40) @(posedge pclk);
    apb(1'h0, `SP_OFF_STAT, 32'h0);
    `CHK("mode 0 one byte", 32'h0, rd)
    $display("test mode 0 done");
    apb(1'h1, `SP_OFF_CTRL, 32'hF8);
    presetn <= 1'h0;
    @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, `SP_OFF_CTRL, 32'h0);
    `CHK("ctrl after reset", 32'h0, rd)
    $display("test mid-run reset done");
    wrap_up();
  end
endmodule : tb
`default_nettype wire
